// [pkg/pwr_ctrl_defs.svh]
// Constants for the power-mode, reset and boot-strap controller
// Contract
// R1: Reset pin low forces full hardware reset; code reboots through ST_BOOT but keeps the stop GPIO number and timer load
// R2: Host drives reset pin open-drain only
// R3: Soft power-off command reboots like hardware reset
// R4: Active/standby switch automatically on activity
// R5: Standby keeps links, wakes without delay
// R6: Auto clock scaling caps baud at 1 Mbaud
// R7: Host alone requests sleep
// R8: Link-control toggle enters/leaves sleep when enabled
// R9: Asleep: hold back data and unsolicited results
// R10: Sleep only in station mode or radio off
// R11: Stop drops everything; wake always reboots
// R12: Link-control toggle enters/leaves stop when enabled
// R13: Stop config selects one GPIO for stop control
// R14: Stop config arms wake timer with user delay
// R15: Command-mode start sends boot-ready banner
// R16: Factory strap low selects factory boot
// R17: Boot-log strap gates log; later chip-select
// R18: Flash strap high selects 1.8 V; later data out
// R19: After boot watch four lines to pick interface
// R20: Radios time-share antenna, never simultaneous
// R21: Straps sampled once at reset release
`ifndef PWR_CTRL_DEFS_SVH
`define PWR_CTRL_DEFS_SVH

// ------------------------------------------------------------
// Timing and widths
// ------------------------------------------------------------
`define CLK_HZ           100000000
`define FAST_BAUD_MAX    3000000
`define SCALED_BAUD_MAX  1000000
`define BOOT_CYCLES      16
`define GPIO_W           5
`define TIMER_W          24
`define SCLK_DETECT      8

`endif

// [pkg/pwr_ctrl_pkg.sv]
// Types shared by both ends of the power-mode link
package pwr_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_BOOT    = 3'b000,
        ST_ACTIVE  = 3'b001,
        ST_STANDBY = 3'b010,
        ST_SLEEP   = 3'b011,
        ST_STOP    = 3'b100
    } pwr_state_t;

    typedef enum logic [2:0] {
        CMD_NONE      = 3'b000,
        CMD_POWEROFF  = 3'b001,
        CMD_SLEEP_EN  = 3'b010,
        CMD_STOP_EN   = 3'b011,
        CMD_STOP_CFG  = 3'b100,
        CMD_PWR_MGMT  = 3'b101
    } cmd_t;

    typedef enum logic [1:0] {
        IF_NONE = 2'b00,
        IF_UART = 2'b01,
        IF_RMII = 2'b10,
        IF_SPI  = 2'b11
    } cmd_if_t;
endpackage

// [pkg/pwr_link_if.sv]
// Link between the host and the power-mode controller
`timescale 1ns/10ps
`include "pwr_ctrl_defs.svh"
interface pwr_link_if;
    import pwr_ctrl_pkg::*;
    // Reset pin: open drain from host, pulled up inside device
    logic                rstPinOe;
    logic                rstPin;
    // Command channel
    logic                cmdValid;
    cmd_t                cmd;
    logic [`TIMER_W-1:0] cmdArg;
    logic                cmdReady;
    // Link-control and stop GPIO lines
    logic                linkCtrl;
    logic [31:0]         gpioIn;
    // Strap pins, host ties all three high
    logic                strapFactory;
    logic                strapBootLog;
    logic                strapFlashV;
    // Interface-detect lines
    logic                rmiiClkSeen;
    logic                uartRx;
    logic                periphSclk;
    logic                periphDataReady;
    // Device status
    logic                bootReadyBanner;
    logic                asleep;
    logic                stopped;
    logic [1:0]          cmdIf;

    assign rstPin = rstPinOe ? 1'b0 : 1'b1;

    modport device (input rstPin, cmdValid, cmd, cmdArg, linkCtrl, gpioIn,
                    strapFactory, strapBootLog, strapFlashV, rmiiClkSeen,
                    uartRx, periphSclk,
                    output cmdReady, periphDataReady, bootReadyBanner,
                    asleep, stopped, cmdIf);
    modport host (output rstPinOe, cmdValid, cmd, cmdArg, linkCtrl, gpioIn,
                  strapFactory, strapBootLog, strapFlashV, rmiiClkSeen,
                  uartRx, periphSclk,
                  input rstPin, cmdReady, periphDataReady, bootReadyBanner,
                  asleep, stopped, cmdIf);
endinterface

// [core/pwr_mode_ctrl.sv]
// Device end: power modes, reboot, straps and interface detect
`timescale 1ns/10ps
`include "pwr_ctrl_defs.svh"
module pwr_mode_ctrl
    import pwr_ctrl_pkg::*;
#(
    parameter int BOOT_CYCLES = `BOOT_CYCLES
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    // Link to host
    pwr_link_if.device       link,
    // Device-side status
    input  wire logic        radioStation,
    input  wire logic        radioOff,
    input  wire logic        ifActivity,
    input  wire logic        radioActivity,
    input  wire logic        startCmdMode,
    input  wire logic        rxDataValid,
    input  wire logic        btWants,
    input  wire logic        wifiWants,
    output logic             fwdEnable,
    output logic             factoryBoot,
    output logic             bootLogEn,
    output logic             flash18v,
    output logic             strapFault,
    output logic [31:0]      baudMax,
    output logic             btGrant,
    output logic             wifiGrant,
    output logic [1:0]       pwrState
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pwr_state_t          state_r;
    logic                reboot;
    logic [7:0]          bootCnt_r;
    logic                strapTaken_r;
    logic                sleepEn_r;
    logic                stopEn_r;
    logic                scaling_r;
    logic                gpioArm_r;
    logic [`GPIO_W-1:0]  gpioSel_r;
    logic                timerArm_r;
    logic [`TIMER_W-1:0] timerLoad_r;
    logic [`TIMER_W-1:0] timer_r;
    logic                linkPrev_r;
    logic                gpioPrev_r;
    logic                linkTog;
    logic                gpioTog;
    logic                sclkPrev_r;
    logic [3:0]          sclkCnt_r;
    cmd_if_t             cmdIf_r;
    logic                banner_r;
    logic                btTurn_r;
    logic                gpioNow;

    assign gpioNow = link.gpioIn[gpioSel_r];
    assign linkTog = link.linkCtrl ^ linkPrev_r;
    assign gpioTog = gpioArm_r & (gpioNow ^ gpioPrev_r);
    // Soft power-off and stop wake both force reboot
    assign reboot = (link.cmdValid && link.cmd == CMD_POWEROFF) // R3
        || (state_r == ST_STOP && ((stopEn_r && linkTog) || gpioTog
        || (timerArm_r && timer_r == '0))); // R11 R12 R13 R14
    assign link.cmdReady = (state_r == ST_ACTIVE) || (state_r == ST_STANDBY);

    // ------------------------------------------------------------
    // Power state machine; pin reset handled by the rstPin check  // R1
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= ST_BOOT;
            bootCnt_r <= 8'h00;
        end else if (clkEn) begin
            if (reboot || !link.rstPin) begin // R1 R3 R11
                state_r   <= ST_BOOT;
                bootCnt_r <= 8'h00;
            end else begin
                unique case (state_r)
                    ST_BOOT: begin
                        bootCnt_r <= bootCnt_r + 8'h01;
                        if (bootCnt_r == 8'(BOOT_CYCLES - 1))
                            state_r <= ST_STANDBY;
                    end
                    ST_ACTIVE, ST_STANDBY: begin
                        // Host toggles only; never self-entered  // R7
                        if (sleepEn_r && linkTog && (radioStation || radioOff))
                            state_r <= ST_SLEEP; // R8 R10
                        else if ((stopEn_r && linkTog) || gpioTog)
                            state_r <= ST_STOP; // R12 R13
                        else if (ifActivity || radioActivity)
                            state_r <= ST_ACTIVE; // R4 R5
                        else
                            state_r <= ST_STANDBY; // R4
                    end
                    ST_SLEEP: begin
                        if (sleepEn_r && linkTog)
                            state_r <= ST_ACTIVE; // R8
                    end
                    ST_STOP: state_r <= ST_STOP;
                    default: state_r <= ST_BOOT;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Command enables and arms cleared by every reboot; GPIO number and timer load kept
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sleepEn_r   <= 1'b0;
            stopEn_r    <= 1'b0;
            scaling_r   <= 1'b0;
            gpioArm_r   <= 1'b0;
            gpioSel_r   <= '0;
            timerArm_r  <= 1'b0;
            timerLoad_r <= '0;
        end else if (clkEn) begin
            if (state_r == ST_BOOT) begin
                sleepEn_r  <= 1'b0;
                stopEn_r   <= 1'b0;
                scaling_r  <= 1'b0;
                gpioArm_r  <= 1'b0;
                timerArm_r <= 1'b0;
            end else if (link.cmdValid && link.cmdReady) begin
                unique case (link.cmd)
                    // Link-control serves one mode at a time; latest wins
                    CMD_SLEEP_EN: begin
                        sleepEn_r <= 1'b1; // R8
                        stopEn_r  <= 1'b0;
                    end
                    CMD_STOP_EN: begin
                        stopEn_r  <= 1'b1; // R12
                        sleepEn_r <= 1'b0;
                    end
                    CMD_PWR_MGMT: scaling_r <= link.cmdArg[0];
                    CMD_STOP_CFG: begin
                        // Bit 23 picks timer, else GPIO number  // R13 R14
                        if (link.cmdArg[`TIMER_W-1]) begin
                            timerArm_r  <= 1'b1;
                            timerLoad_r <= {1'b0, link.cmdArg[`TIMER_W-2:0]};
                        end else begin
                            gpioArm_r <= 1'b1;
                            gpioSel_r <= link.cmdArg[`GPIO_W-1:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Edge history and wake timer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            linkPrev_r <= 1'b1;
            gpioPrev_r <= 1'b0;
            timer_r    <= '0;
        end else if (clkEn) begin
            linkPrev_r <= link.linkCtrl;
            gpioPrev_r <= gpioNow;
            if (state_r != ST_STOP)
                timer_r <= timerLoad_r;
            else if (timer_r != '0)
                timer_r <= timer_r - 1'b1; // R14
        end
    end

    // ------------------------------------------------------------
    // Straps captured once per boot  // R21
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strapTaken_r <= 1'b0;
            factoryBoot  <= 1'b0;
            bootLogEn    <= 1'b1;
            flash18v     <= 1'b1;
        end else if (clkEn) begin
            if (state_r != ST_BOOT)
                strapTaken_r <= 1'b0;
            else if (!strapTaken_r) begin
                strapTaken_r <= 1'b1; // R21
                factoryBoot  <= ~link.strapFactory; // R16
                bootLogEn    <= link.strapBootLog; // R17
                flash18v     <= link.strapFlashV; // R18
            end
        end
    end
    assign strapFault = ~flash18v; // R18

    // ------------------------------------------------------------
    // Interface detect, banner, data-ready toggle  // R19 R15
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdIf_r    <= IF_NONE;
            sclkPrev_r <= 1'b0;
            sclkCnt_r  <= 4'h0;
            banner_r   <= 1'b0;
            link.periphDataReady <= 1'b0;
        end else if (clkEn) begin
            banner_r   <= 1'b0;
            sclkPrev_r <= link.periphSclk;
            if (state_r == ST_BOOT) begin
                cmdIf_r   <= IF_NONE;
                sclkCnt_r <= 4'h0;
                if (bootCnt_r == 8'(BOOT_CYCLES - 1))
                    banner_r <= startCmdMode; // R15
            end else if (cmdIf_r == IF_NONE) begin
                link.periphDataReady <= ~link.periphDataReady;
                if (link.periphSclk && !sclkPrev_r)
                    sclkCnt_r <= sclkCnt_r + 4'h1;
                if (link.rmiiClkSeen)
                    cmdIf_r <= IF_RMII; // R19
                else if (!link.uartRx) begin
                    cmdIf_r <= IF_UART; // R19
                    link.periphDataReady <= 1'b0;
                end else if (sclkCnt_r == 4'(`SCLK_DETECT))
                    cmdIf_r <= IF_SPI; // R19
            end
        end
    end

    // ------------------------------------------------------------
    // Antenna arbiter: one radio at a time, alternating  // R20
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            btTurn_r  <= 1'b0;
            btGrant   <= 1'b0;
            wifiGrant <= 1'b0;
        end else if (clkEn) begin
            btTurn_r  <= ~btTurn_r;
            btGrant   <= btWants && (btTurn_r || !wifiWants); // R20
            wifiGrant <= wifiWants && !(btWants && (btTurn_r || !wifiWants));
        end
    end

    // Outputs
    assign fwdEnable = rxDataValid && state_r != ST_SLEEP
        && state_r != ST_STOP && state_r != ST_BOOT; // R9
    assign baudMax = scaling_r ? `SCALED_BAUD_MAX : `FAST_BAUD_MAX; // R6
    assign link.bootReadyBanner = banner_r;
    assign link.asleep  = (state_r == ST_SLEEP);
    assign link.stopped = (state_r == ST_STOP);
    assign link.cmdIf   = cmdIf_r;
    assign pwrState     = state_r[1:0];
endmodule

// [core/pwr_host_ctrl.sv]
// Host end: drives reset, commands and the link-control toggle
`timescale 1ns/10ps
`include "pwr_ctrl_defs.svh"
module pwr_host_ctrl
    import pwr_ctrl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                clkEn,
    // Link to device
    pwr_link_if.host                 link,
    // User requests
    input  wire logic                resetReq,
    input  wire logic                cmdReq,
    input  wire cmd_t                cmdIn,
    input  wire logic [`TIMER_W-1:0] argIn,
    input  wire logic                toggleReq,
    input  wire logic [31:0]         gpioDrive,
    input  wire logic                uartRxIn,
    input  wire logic                sclkIn,
    input  wire logic                rmiiClkIn,
    output logic                     cmdBusy,
    output logic                     deviceAsleep,
    output logic                     deviceStopped
);
    // ------------------------------------------------------------
    // Reset drive: open drain only, never high  // R2
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            link.rstPinOe <= 1'b0;
        else if (clkEn)
            link.rstPinOe <= resetReq; // R2
    end

    // ------------------------------------------------------------
    // Command issue and link-control toggle  // R7 R8 R12
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link.cmdValid <= 1'b0;
            link.cmd      <= CMD_NONE;
            link.cmdArg   <= '0;
            link.linkCtrl <= 1'b1;
        end else if (clkEn) begin
            if (link.cmdValid && link.cmdReady)
                link.cmdValid <= 1'b0;
            else if (cmdReq && !link.cmdValid) begin
                link.cmdValid <= 1'b1;
                link.cmd      <= cmdIn;
                link.cmdArg   <= argIn;
            end
            if (toggleReq)
                link.linkCtrl <= ~link.linkCtrl; // R7 R8 R12
        end
    end

    // Straps left at their pull-up defaults  // R18
    assign link.strapFactory = 1'b1;
    assign link.strapBootLog = 1'b1;
    assign link.strapFlashV  = 1'b1;
    assign link.gpioIn       = gpioDrive;
    assign link.uartRx       = uartRxIn;
    assign link.periphSclk   = sclkIn;
    assign link.rmiiClkSeen  = rmiiClkIn;
    assign cmdBusy       = link.cmdValid;
    assign deviceAsleep  = link.asleep;
    assign deviceStopped = link.stopped;
endmodule

// [bench/pwr_link_monitor.sv]
// Assertion checker watching the power-mode link between both ends
`timescale 1ns/10ps
module pwr_link_monitor
    import pwr_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // Link signals
    input wire logic       rstPin,
    input wire logic       cmdValid,
    input wire cmd_t       cmd,
    input wire logic       cmdReady,
    input wire logic       linkCtrl,
    input wire logic       bootReadyBanner,
    input wire logic       asleep,
    input wire logic       stopped,
    input wire logic [1:0] cmdIf
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    property p_refuse;
        (asleep || stopped) |-> !cmdReady;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("command channel ready while parked");
    property p_excl;
        !(asleep && stopped);
    endproperty
    a_excl: assert property (p_excl)
        else $error("sleep and stop both shown");
    property p_rstPin;
        !rstPin |=> !cmdReady && !asleep && !stopped;
    endproperty
    a_rstPin: assert property (p_rstPin)
        else $error("reset pin low did not reboot");
    property p_sleepIn;
        $rose(asleep) |-> $past(linkCtrl) != $past(linkCtrl, 2);
    endproperty
    a_sleepIn: assert property (p_sleepIn)
        else $error("sleep entered without a toggle");
    property p_sleepOut;
        $fell(asleep) |-> ($past(linkCtrl) != $past(linkCtrl, 2))
            || !$past(rstPin);
    endproperty
    a_sleepOut: assert property (p_sleepOut)
        else $error("sleep left without a toggle");
    property p_stopWake;
        $fell(stopped) |-> !cmdReady;
    endproperty
    a_stopWake: assert property (p_stopWake)
        else $error("stop wake skipped the reboot");
    property p_bannerPulse;
        $rose(bootReadyBanner) |=> !bootReadyBanner;
    endproperty
    a_bannerPulse: assert property (p_bannerPulse)
        else $error("banner longer than one cycle");
    property p_quiet;
        asleep |-> !bootReadyBanner;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("banner sent while asleep");
    property p_poweroff;
        cmdValid && cmd == CMD_POWEROFF |=> !cmdReady ##1 !cmdReady;
    endproperty
    a_poweroff: assert property (p_poweroff)
        else $error("power-off command did not reboot");
    property p_rebootLen;
        !rstPin ##1 rstPin |-> !cmdReady [*3] ##[1:20] cmdReady;
    endproperty
    a_rebootLen: assert property (p_rebootLen)
        else $error("reboot length wrong");

    // Main scenarios reached
    c_sleep: cover property ($rose(asleep));
    c_stop: cover property ($rose(stopped));
    c_banner: cover property (bootReadyBanner);
    c_spi: cover property (cmdIf == IF_SPI);
endmodule

// [bench/tb.sv]
// Self-checking bench for host and device ends of the power-mode link
`timescale 1ns/10ps
`include "pwr_ctrl_defs.svh"
module tb;
    import pwr_ctrl_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk = 1'b0, rst_b = 1'b0;
    logic        clkEn = 1'b1;
    int          bad_count = 0, samples_checked = 0;
    logic        radioStation = 1'b0, radioOff = 1'b0, ifActivity = 1'b0;
    logic        radioActivity = 1'b0, startCmdMode = 1'b1;
    logic        rxDataValid = 1'b0, btWants = 1'b0, wifiWants = 1'b0;
    logic        resetReq = 1'b0, cmdReq = 1'b0, toggleReq = 1'b0;
    cmd_t        cmdIn = CMD_NONE;
    logic [23:0] argIn = 24'h0;
    logic [31:0] gpioDrive = 32'h0, baudMax;
    logic        uartRxIn = 1'b1, sclkIn = 1'b0, rmiiClkIn = 1'b0;
    logic        fwdEnable, factoryBoot, bootLogEn, flash18v, strapFault;
    logic        btGrant, wifiGrant, cmdBusy, deviceAsleep, deviceStopped;
    logic [1:0]  pwrState;

    pwr_link_if link ();
    pwr_mode_ctrl #(.BOOT_CYCLES(4)) pwr_mode_ctrl_inst (.clk(clk),
        .rst_b(rst_b), .clkEn(clkEn), .link(link),
        .radioStation(radioStation), .radioOff(radioOff),
        .ifActivity(ifActivity), .radioActivity(radioActivity),
        .startCmdMode(startCmdMode), .rxDataValid(rxDataValid),
        .btWants(btWants), .wifiWants(wifiWants), .fwdEnable(fwdEnable),
        .factoryBoot(factoryBoot), .bootLogEn(bootLogEn),
        .flash18v(flash18v), .strapFault(strapFault), .baudMax(baudMax),
        .btGrant(btGrant), .wifiGrant(wifiGrant), .pwrState(pwrState));
    pwr_host_ctrl pwr_host_ctrl_inst (.clk(clk), .rst_b(rst_b),
        .clkEn(clkEn), .link(link), .resetReq(resetReq), .cmdReq(cmdReq),
        .cmdIn(cmdIn), .argIn(argIn), .toggleReq(toggleReq),
        .gpioDrive(gpioDrive), .uartRxIn(uartRxIn), .sclkIn(sclkIn),
        .rmiiClkIn(rmiiClkIn), .cmdBusy(cmdBusy),
        .deviceAsleep(deviceAsleep), .deviceStopped(deviceStopped));
    pwr_link_monitor pwr_link_monitor_inst (.clk(clk), .rst_b(rst_b),
        .rstPin(link.rstPin), .cmdValid(link.cmdValid), .cmd(link.cmd),
        .cmdReady(link.cmdReady), .linkCtrl(link.linkCtrl),
        .bootReadyBanner(link.bootReadyBanner), .asleep(link.asleep),
        .stopped(link.stopped), .cmdIf(link.cmdIf));

    // 100 MHz clock
    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Level watched by the bounded wait
    function automatic logic pick(input int w);
        case (w)
            0: return link.cmdReady;
            1: return link.bootReadyBanner;
            2: return link.stopped;
            default: return !link.stopped;
        endcase
    endfunction
    task automatic waitOn(input int w, input int lim);
        int n;
        n = 0;
        while (pick(w) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (pick(w) !== 1'b1) begin
            bad_count++;
            $display("[ERR] t=%0t wait %0d timed out", $time, w);
            conclude();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic send(input cmd_t c, input logic [23:0] a);
        cmdReq = 1'b1;
        cmdIn = c;
        argIn = a;
        cyc(1);
        cmdReq = 1'b0;
        cyc(3);
    endtask
    task automatic toggle();
        toggleReq = 1'b1;
        cyc(1);
        toggleReq = 1'b0;
        cyc(3);
    endtask
    task automatic rebootWait();
        waitOn(1, 40);
        waitOn(0, 40);
        cyc(1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic tBoot();
        check(factoryBoot, 1'b0);
        check(bootLogEn, 1'b1);
        check({flash18v, strapFault}, 2'b10);
        check(pwrState, 2'h2);
        // Enable low freezes both ends
        clkEn = 1'b0;
        ifActivity = 1'b1;
        cyc(2);
        check(pwrState, 2'h2);
        clkEn = 1'b1;
        cyc(2);
        check(pwrState, 2'h1);
        ifActivity = 1'b0;
        radioActivity = 1'b1;
        cyc(2);
        check({pwrState, link.cmdReady}, 3'h3);
        radioActivity = 1'b0;
        cyc(2);
        check(pwrState, 2'h2);
    endtask
    task automatic tBaud();
        send(CMD_PWR_MGMT, 24'h1);
        check({cmdBusy, link.cmdReady}, 2'b01);
        check(baudMax, `SCALED_BAUD_MAX);
        send(CMD_PWR_MGMT, 24'h0);
        check(baudMax, `FAST_BAUD_MAX);
    endtask
    task automatic tSleep();
        send(CMD_SLEEP_EN, 24'h0);
        toggle();
        check(link.asleep, 1'b0);
        radioStation = 1'b1;
        toggle();
        check({link.asleep, deviceAsleep}, 2'b11);
        rxDataValid = 1'b1;
        cyc(1);
        check({fwdEnable, link.cmdReady}, 2'b00);
        toggle();
        check({link.asleep, fwdEnable}, 2'b01);
        rxDataValid = 1'b0;
    endtask
    task automatic tStopTimer();
        int n;
        send(CMD_STOP_EN, 24'h0);
        send(CMD_STOP_CFG, 24'h800005);
        toggleReq = 1'b1;
        cyc(1);
        toggleReq = 1'b0;
        waitOn(2, 5);
        check(deviceStopped, 1'b1);
        n = 0;
        while (link.stopped === 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        check(n, 6);
        rebootWait();
        toggle();
        check({link.asleep, link.stopped}, 2'b00);
    endtask
    task automatic tStopGpio();
        send(CMD_STOP_CFG, 24'h000003);
        gpioDrive[3] = 1'b1;
        waitOn(2, 6);
        cyc(3);
        check(link.stopped, 1'b1);
        gpioDrive[3] = 1'b0;
        waitOn(3, 10);
        rebootWait();
    endtask
    task automatic tReset();
        resetReq = 1'b1;
        cyc(2);
        check({link.cmdReady, pwrState}, 3'h0);
        resetReq = 1'b0;
        rebootWait();
        check(pwrState, 2'h2);
    endtask
    task automatic tDetect();
        for (int m = 1; m < 4; m++) begin
            send(CMD_POWEROFF, 24'h0);
            rebootWait();
            for (int i = 0; i < 16; i++) begin
                uartRxIn = (m != 1);
                rmiiClkIn = (m == 2) && !rmiiClkIn;
                sclkIn = (m == 3) && !sclkIn;
                cyc(1);
            end
            cyc(4);
            check(link.cmdIf, m[1:0]);
            if (m == 1)
                check(link.periphDataReady, 1'b0);
            uartRxIn = 1'b1;
        end
    endtask
    task automatic tAntenna();
        int nb, nw;
        nb = 0;
        nw = 0;
        btWants = 1'b1;
        wifiWants = 1'b1;
        repeat (8) begin
            cyc(1);
            check(btGrant & wifiGrant, 1'b0);
            nb += int'(btGrant);
            nw += int'(wifiGrant);
        end
        check({nb > 0, nw > 0}, 2'b11);
        btWants = 1'b0;
        wifiWants = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(5);
        rst_b = 1'b1;
        rebootWait();
        tBoot();
        tBaud();
        tSleep();
        tStopTimer();
        tStopGpio();
        tReset();
        tDetect();
        tAntenna();
        conclude();
    end
endmodule
